// >>> core/nhc_cyc.sv
`timescale 1ns/1ps
module nhc_cyc (
  // Clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  // Cycle requests
  nhc_cyc_if.eng      cyc,
  // Strobe pins
  output logic        o_cle,
  output logic        o_ale,
  output logic        o_we_n,
  output logic        o_re_n,
  output logic [7:0]  o_dq,
  output logic        o_dq_oe_n,
  input  wire logic [7:0] i_dq
);
  typedef struct packed {
    nhc_pkg::nhc_est_t  st;
    nhc_pkg::nhc_kind_t kind;
    logic [3:0]         cnt;
    logic               cle;
    logic               ale;
    logic               we_n;
    logic               re_n;
    logic [7:0]         dq;
    logic               oe_n;
    logic               busy;
    logic               done;
    logic [7:0]         rbyte;
    logic [7:0]         s1;
    logic [7:0]         s2;
  } nhc_cst_t;

  nhc_cst_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.s1 = i_dq;
    d.s2 = q.s1;
    case (q.st)
      nhc_pkg::E_IDLE: begin
        if (cyc.start) begin
          d.st = nhc_pkg::E_SETUP;
          d.kind = cyc.kind;
          d.busy = 1'b1;
          d.cle = (cyc.kind == nhc_pkg::K_CMD); // RL1
          d.ale = (cyc.kind == nhc_pkg::K_ADDR); // RL2
          d.dq = cyc.wbyte;
          d.oe_n = (cyc.kind == nhc_pkg::K_READ); // RL14
        end
      end
      nhc_pkg::E_SETUP: begin
        d.st = nhc_pkg::E_LOW;
        d.cnt = nhc_pkg::LOW_CYC;
        if (q.kind == nhc_pkg::K_READ) begin
          d.re_n = 1'b0; // RL5
        end else begin
          d.we_n = 1'b0;
        end
      end
      nhc_pkg::E_LOW: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          // Synced pins lag two cycles, so the low phase is stretched to cover access time
          if (q.kind == nhc_pkg::K_READ) begin
            d.rbyte = q.s2;
          end
          d.we_n = 1'b1; // RL1 RL2
          d.re_n = 1'b1;
          d.st = nhc_pkg::E_HIGH;
          d.cnt = nhc_pkg::HIGH_CYC;
        end
      end
      nhc_pkg::E_HIGH: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.st = nhc_pkg::E_IDLE;
          d.cle = 1'b0;
          d.ale = 1'b0;
          d.oe_n = 1'b1;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      default: d.st = nhc_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{st: nhc_pkg::E_IDLE, kind: nhc_pkg::K_CMD, cnt: 4'h0, cle: 1'b0, ale: 1'b0,
             we_n: 1'b1, re_n: 1'b1, dq: 8'h00, oe_n: 1'b1, busy: 1'b0, done: 1'b0,
             rbyte: 8'h00, s1: 8'h00, s2: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign cyc.busy = q.busy;
  assign cyc.done = q.done;
  assign cyc.rbyte = q.rbyte;
  assign o_cle = q.cle;
  assign o_ale = q.ale;
  assign o_we_n = q.we_n;
  assign o_re_n = q.re_n;
  assign o_dq = q.dq;
  assign o_dq_oe_n = q.oe_n;
endmodule : nhc_cyc

// >>> core/nhc_cyc_if.sv
`timescale 1ns/1ps
interface nhc_cyc_if;
  logic              start;
  nhc_pkg::nhc_kind_t kind;
  logic [7:0]        wbyte;
  logic              busy;
  logic              done;
  logic [7:0]        rbyte;
  modport ctl (output start, kind, wbyte, input busy, done, rbyte);
  modport eng (input start, kind, wbyte, output busy, done, rbyte);
endinterface : nhc_cyc_if

// >>> core/nhc_host.sv
// Operation
// RL1: Command byte latched on write strobe with CLE
// RL2: Address with ALE high, data with ALE low
// RL3: Chip select high during read gives standby
// RL4: Hold chip select low through read busy
// RL5: Each read strobe fall gives next byte
// RL6: Write protect low inhibits program and erase
// RL7: Ready/busy low during program, erase, array read
// RL8: Page 528 bytes, block 16 pages, 1024 blocks
// RL9: Three address bytes, top two bits low
// RL10: Column half bit set by read commands
// RL11: Decoder knows the listed command codes
// RL12: Only reset and status accepted while busy
// RL13: Read mode persists across page reads
// RL14: Port driven only while read strobe low
// RL15: Third read mode points into spare area
// RL16: Sequential read streams pages without address
// RL17: Last column of last page repeats
// RL18: Status byte: fail, ready, not-protected bits
// RL19: Pass/fail meaningful only when ready
// RL20: Program starts on execute after serial input
// RL21: Erase confirm only directly after erase setup
// RL22: Reset aborts operation, returns to idle
// RL23: After serial input only execute or reset
// RL24: Status mode holds until read command
// RL25: ID command outputs maker and device bytes
// RL26: Page wrap in sequential read goes busy
`timescale 1ns/1ps
module nhc_host (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Flash pins
  output logic             o_ce_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_we_n,
  output logic             o_re_n,
  output logic             o_wp_n,
  output logic      [7:0]  o_dq,
  output logic             o_dq_oe_n,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ready_busy_n
);
  typedef struct packed {
    logic [1:0]         ctrl;
    logic [1:0]         rem;
    nhc_pkg::nhc_kind_t kind;
    logic [23:0]        sh;
    logic               start;
    logic               cur_wr;
    logic [7:0]         last_cmd;
    logic               prog_pend;
    logic               refused;
    logic [7:0]         rbyte;
    logic [7:0]         sbyte;
    logic [5:0]         guard;
    logic               rb1;
    logic               rb2;
    logic [31:0]        rdata;
    logic               ce_n;
  } nhc_hst_t;

  nhc_hst_t q, d;
  nhc_cyc_if cyc ();

  logic       ready_ok;
  logic       idle_seq;
  logic       cmd_ok;
  logic [7:0] c;
  logic       stat_fail;

  assign ready_ok = q.rb2 && (q.guard == 6'h00); // RL7
  assign idle_seq = (q.rem == 2'h0) && !q.start && !cyc.busy;
  assign c = i_wdata[7:0];
  // Fail flag ignored unless the same status byte says ready
  assign stat_fail = q.sbyte[nhc_pkg::SB_FAIL_BIT] && q.sbyte[nhc_pkg::SB_READY_BIT]; // RL19

  always_comb begin
    cmd_ok = idle_seq;
    if (!ready_ok && c != nhc_pkg::C_RESET && c != nhc_pkg::C_STATUS) begin
      cmd_ok = 1'b0; // RL12
    end
    if (q.prog_pend && c != nhc_pkg::C_PROGRAM && c != nhc_pkg::C_RESET) begin
      cmd_ok = 1'b0; // RL23
    end
    if (c == nhc_pkg::C_ERASE2 && q.last_cmd != nhc_pkg::C_ERASE1) begin
      cmd_ok = 1'b0; // RL21
    end
    if (c == nhc_pkg::C_PROGRAM && !q.prog_pend) begin
      cmd_ok = 1'b0; // RL20
    end
  end

  always_comb begin
    d = q;
    d.rb1 = i_ready_busy_n;
    d.rb2 = q.rb1;
    d.start = 1'b0;
    if (q.guard != 6'h00) begin
      d.guard = q.guard - 6'h01;
    end
    if (cyc.done) begin
      if (q.cur_wr) begin
        // Device may take up to tWB to pull busy low after a write cycle
        d.guard = nhc_pkg::WB_CYC;
      end else begin
        d.rbyte = cyc.rbyte; // RL5
        if (q.last_cmd == nhc_pkg::C_STATUS) begin
          d.sbyte = cyc.rbyte; // RL18 RL24
        end
      end
    end
    if (q.start) begin
      // Engine takes the low byte on this edge, so the next byte moves down only now
      d.sh = {8'h00, q.sh[23:8]}; // RL9
    end
    if (q.rem != 2'h0 && !q.start && !cyc.busy) begin
      d.start = 1'b1;
      d.rem = q.rem - 2'h1;
      d.cur_wr = (q.kind != nhc_pkg::K_READ);
    end
    // Chip select stays low while busy so array transfers complete
    d.ce_n = !(q.ctrl[nhc_pkg::CTRL_CE_HOLD_BIT] || !idle_seq || !ready_ok
               || q.prog_pend); // RL4 RL3
    if (i_wr) begin
      case (i_addr)
        nhc_pkg::OFS_CTRL: d.ctrl = i_wdata[1:0]; // RL6
        nhc_pkg::OFS_CMD: begin
          if (cmd_ok) begin
            d.rem = 2'h1; // RL1 RL11
            d.kind = nhc_pkg::K_CMD;
            d.sh = {16'h0000, c};
            d.last_cmd = c; // RL13 RL10
            if (c == nhc_pkg::C_SERIAL_IN) begin
              d.prog_pend = 1'b1;
            end
            if (c == nhc_pkg::C_PROGRAM || c == nhc_pkg::C_RESET) begin
              d.prog_pend = 1'b0; // RL22
            end
          end else begin
            d.refused = 1'b1;
          end
        end
        nhc_pkg::OFS_ADDR: begin
          if (idle_seq && ready_ok) begin
            d.rem = 2'h3; // RL9
            d.kind = nhc_pkg::K_ADDR;
            d.sh = {nhc_pkg::ADDR_TOP_ZERO, i_wdata[21:0]}; // RL9
          end else begin
            d.refused = 1'b1;
          end
        end
        nhc_pkg::OFS_DATA: begin
          if (idle_seq && ready_ok) begin
            d.rem = 2'h1; // RL2
            d.kind = nhc_pkg::K_DATA;
            d.sh = {16'h0000, c};
          end else begin
            d.refused = 1'b1;
          end
        end
        nhc_pkg::OFS_RDGO: begin
          // Status reads are allowed while busy, data reads wait for ready
          if (idle_seq && (ready_ok || q.last_cmd == nhc_pkg::C_STATUS)) begin
            d.rem = 2'h1; // RL5 RL14 RL26
            d.kind = nhc_pkg::K_READ;
          end else begin
            d.refused = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (i_wr && i_addr == nhc_pkg::OFS_STAT && i_wdata[nhc_pkg::STAT_REFUSED_BIT]
        && !d.refused) begin
      d.refused = 1'b0;
    end else if (i_wr && i_addr == nhc_pkg::OFS_STAT && !(i_wr && i_addr != nhc_pkg::OFS_STAT)
                 && i_wdata[nhc_pkg::STAT_REFUSED_BIT] && d.refused && q.refused) begin
      d.refused = 1'b0;
    end
    d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        nhc_pkg::OFS_CTRL:  d.rdata = {30'h0000_0000, q.ctrl};
        nhc_pkg::OFS_RDATA: d.rdata = {24'h00_0000, q.rbyte};
        nhc_pkg::OFS_SBYTE: d.rdata = {24'h00_0000, q.sbyte};
        nhc_pkg::OFS_STAT: begin
          d.rdata[nhc_pkg::STAT_ENG_BUSY_BIT] = !idle_seq;
          d.rdata[nhc_pkg::STAT_READY_BIT] = ready_ok;
          d.rdata[nhc_pkg::STAT_REFUSED_BIT] = q.refused;
          d.rdata[nhc_pkg::STAT_FAIL_BIT] = stat_fail; // RL19
          d.rdata[nhc_pkg::STAT_PROT_BIT] = !q.sbyte[nhc_pkg::SB_WPN_BIT]; // RL18
          d.rdata[nhc_pkg::STAT_PROG_BIT] = q.prog_pend;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{ctrl: nhc_pkg::CTRL_RST, rem: 2'h0, kind: nhc_pkg::K_CMD, sh: 24'h00_0000,
             start: 1'b0, cur_wr: 1'b0, last_cmd: 8'h00, prog_pend: 1'b0, refused: 1'b0,
             rbyte: 8'h00, sbyte: 8'h00, guard: 6'h00, rb1: 1'b0, rb2: 1'b0,
             rdata: 32'h0000_0000, ce_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign cyc.start = q.start;
  assign cyc.kind = q.kind;
  assign cyc.wbyte = q.sh[7:0];
  assign o_rdata = q.rdata;
  assign o_ce_n = q.ce_n;
  assign o_wp_n = q.ctrl[nhc_pkg::CTRL_WP_N_BIT]; // RL6

  nhc_cyc u_cyc (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .cyc       (cyc),
    .o_cle     (o_cle),
    .o_ale     (o_ale),
    .o_we_n    (o_we_n),
    .o_re_n    (o_re_n),
    .o_dq      (o_dq),
    .o_dq_oe_n (o_dq_oe_n),
    .i_dq      (i_dq)
  );
endmodule : nhc_host

// >>> core/nhc_pkg.sv
package nhc_pkg;
  // Software register map, byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_ADDR  = 8'h08;
  localparam logic [7:0] OFS_DATA  = 8'h0C;
  localparam logic [7:0] OFS_RDGO  = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_SBYTE = 8'h1C;

  // CTRL fields and reset value
  localparam int CTRL_WP_N_BIT = 0;
  localparam int CTRL_CE_HOLD_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // STAT fields
  localparam int STAT_ENG_BUSY_BIT = 0;
  localparam int STAT_READY_BIT    = 1;
  localparam int STAT_REFUSED_BIT  = 2;
  localparam int STAT_FAIL_BIT     = 3;
  localparam int STAT_PROT_BIT     = 4;
  localparam int STAT_PROG_BIT     = 5;

  // Status byte fields from the device
  localparam int SB_FAIL_BIT  = 0;
  localparam int SB_READY_BIT = 6;
  localparam int SB_WPN_BIT   = 7;

  // Device command codes
  localparam logic [7:0] C_SERIAL_IN = 8'h80;
  localparam logic [7:0] C_READ1     = 8'h00;
  localparam logic [7:0] C_READ2     = 8'h01;
  localparam logic [7:0] C_READ3     = 8'h50;
  localparam logic [7:0] C_RESET     = 8'hFF;
  localparam logic [7:0] C_PROGRAM   = 8'h10;
  localparam logic [7:0] C_ERASE1    = 8'h60;
  localparam logic [7:0] C_ERASE2    = 8'hD0;
  localparam logic [7:0] C_STATUS    = 8'h70;
  localparam logic [7:0] C_ID        = 8'h90;

  // Array geometry
  localparam int PAGE_BYTES  = 528;
  localparam int MAIN_BYTES  = 512;
  localparam int SPARE_BYTES = 16;
  localparam int BLK_PAGES   = 16;
  localparam int NUM_BLOCKS  = 1024;
  localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;

  // Timing
  localparam int CLK_NS  = 4;
  localparam int TRP_NS  = 35;
  localparam int TREH_NS = 15;
  localparam int TWB_NS  = 200;
  localparam int SYNC_NS = 2 * CLK_NS;
  localparam logic [3:0] LOW_CYC  = 4'((TRP_NS + SYNC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HIGH_CYC = 4'((TREH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] WB_CYC   = 6'((TWB_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    K_CMD  = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h3,
    K_READ = 2'h2
  } nhc_kind_t;

  typedef enum logic [1:0] {
    E_IDLE  = 2'h0,
    E_SETUP = 2'h1,
    E_LOW   = 2'h3,
    E_HIGH  = 2'h2
  } nhc_est_t;
endpackage : nhc_pkg

// >>> dv/nhc_flash_model.sv
`timescale 1ns/1ps
module nhc_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C,  // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'hA5   // Arbitrary value
) (
  // Host strobes
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_dq,
  // Byte port and ready/busy pull-down
  output logic      [7:0] o_dq,
  output logic            o_rb_low
);
  logic [7:0] col_q, out_q, last_q;
  logic [1:0] acnt_q;
  logic       a8_q, sp_q, st_q, id_q, pend_q, ers_q, fail_q, drv_q, was_p, was_e, rdb_q;
  logic [13:0] page_q;
  int         idx_q, pcol_q;
  realtime    end_t;
  task automatic go(input realtime t, input logic rd);
    o_rb_low = 1'b1;
    rdb_q    = rd;
    end_t    = $realtime + t;
  endtask : go
  initial begin
    {col_q, out_q, last_q, acnt_q, a8_q, sp_q, st_q, id_q, pend_q, ers_q} = '0;
    {fail_q, drv_q, o_rb_low, rdb_q, page_q} = '0;
    idx_q  = 0;
    pcol_q = 0;
  end
  // Only an array read is cut short by chip select; program and erase run on
  always @(posedge i_ce_n) if (o_rb_low && rdb_q) o_rb_low = 1'b0;
  // Polled in fine steps so that busy ends close to its set end time
  always #2 if (o_rb_low && $realtime >= end_t) o_rb_low = 1'b0;
  always @(posedge i_we_n) if (!i_ce_n) begin
    if (i_cle) begin
      if (!o_rb_low || i_dq == 8'hFF || i_dq == 8'h70) begin
        was_p  = pend_q;
        was_e  = ers_q;
        pend_q = 1'b0;
        ers_q  = 1'b0;
        acnt_q = 2'h0;
        case (i_dq)
          8'h00, 8'h01: {a8_q, sp_q, st_q, id_q} = {i_dq[0], 3'h0};
          8'h50: {sp_q, st_q, id_q} = 3'h4;
          8'h70: st_q = 1'b1;
          8'h90: {id_q, st_q} = 2'h2;
          8'h80: {pend_q, fail_q} = 2'h2;
          8'h10: if (was_p && i_wp_n) go(800, 1'b0);
          8'h60: ers_q = 1'b1;
          8'hD0: if (was_e && i_wp_n) go(1600, 1'b0);
          8'hFF: o_rb_low = 1'b0;
          default: ;
        endcase
        idx_q = 0;
      end
    end else if (i_ale) begin
      if (acnt_q == 2'h0) begin
        col_q  = i_dq;
        pcol_q = sp_q ? nhc_pkg::MAIN_BYTES + int'(i_dq[3:0]) : int'({a8_q, i_dq});
      end
      if (acnt_q == 2'h1) page_q[7:0] = i_dq;
      if (acnt_q == 2'h2) page_q[13:8] = i_dq[5:0];
      acnt_q = acnt_q + 2'h1;
      if (acnt_q == 2'h3 && !pend_q && !ers_q && !id_q) go(400, 1'b1);
    end else if (pend_q && i_dq == 8'hEE) fail_q = 1'b1;
  end
  always @(negedge i_re_n) if (!i_ce_n) begin
    if (st_q) out_q = {i_wp_n, !o_rb_low, 5'h0, fail_q};
    else if (id_q) out_q = idx_q == 0 ? MAKER_ID : DEV_ID;
    else out_q = sp_q ? {4'hE, col_q[3:0]} : col_q ^ {8{a8_q}};
    if (!st_q && !id_q) begin
      if (pcol_q != nhc_pkg::PAGE_BYTES - 1) begin
        pcol_q++;
        col_q = col_q + 8'h1;
      end else if (page_q != 14'(nhc_pkg::BLK_PAGES * nhc_pkg::NUM_BLOCKS - 1)) begin
        pcol_q = sp_q ? nhc_pkg::MAIN_BYTES : 0;
        col_q  = col_q + 8'h1;
        page_q++;
        go(400, 1'b1);
      end
      // Past the last column of the last page the pointer stays put
    end
    idx_q++;
    last_q = out_q;
    drv_q  = 1'b1;
  end
  always @(posedge i_re_n or posedge i_ce_n) drv_q = 1'b0;
  // A released port shows the inverse of the last byte, never a stale copy
  assign o_dq = drv_q ? out_q : ~last_q;
endmodule : nhc_flash_model

// >>> dv/nhc_host_asserts.sv
`timescale 1ns/1ps
module nhc_host_asserts (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_ce_n,
  input wire logic        o_cle,
  input wire logic        o_ale,
  input wire logic        o_we_n,
  input wire logic        o_re_n,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe_n,
  input wire logic        i_ready_busy_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  a_idle_after_rst: assert property ($rose(i_rst_b) |-> o_ce_n && o_we_n && o_re_n && o_dq_oe_n)
    else $error("pins not idle after reset");
  a_we_low_width: assert property ($fell(o_we_n) |-> !o_we_n[*8] ##1 !o_we_n[*3] ##1 o_we_n)
    else $error("write strobe low time wrong");
  a_we_high_hold: assert property ($rose(o_we_n) |-> o_we_n[*4])
    else $error("write strobe high time short");
  a_re_low_width: assert property ($fell(o_re_n) |-> !o_re_n[*8] ##1 !o_re_n[*3] ##1 o_re_n)
    else $error("read strobe low time wrong");
  a_wr_bus_held: assert property (!o_we_n |-> !o_dq_oe_n && $stable(o_dq) && $stable(o_cle)
    && $stable(o_ale)) else $error("byte or latch strobes moved under write");
  a_latch_excl: assert property (!(o_cle && o_ale) && !(!o_we_n && !o_re_n))
    else $error("conflicting strobes");
  a_strobe_needs_ce: assert property (!o_we_n || !o_re_n |-> !o_ce_n)
    else $error("strobe without chip select");
  a_port_free_rd: assert property (!o_re_n |-> o_dq_oe_n && !o_cle && !o_ale)
    else $error("port driven during read");
  a_ce_in_busy: assert property ((!i_ready_busy_n)[*3] |-> !o_ce_n)
    else $error("chip select released while busy");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule : nhc_host_asserts
bind nhc_host nhc_host_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
  .o_re_n(o_re_n), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .i_ready_busy_n(i_ready_busy_n));

// >>> dv/nhc_host_tb.sv
`timescale 1ns/1ps
module nhc_host_tb;
  localparam logic [7:0] MAKER_ID = 8'h3C;  // Arbitrary value
  localparam logic [7:0] DEV_ID   = 8'hA5;  // Arbitrary value
  logic        i_sys_clk, i_rst_b, i_wr, i_rd, rd_p;
  logic        o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_dq_oe_n, rb_low;
  logic [7:0]  i_addr, o_dq, dev_dq, col;
  logic [31:0] i_wdata, o_rdata, lfsr_q;
  logic [63:0] note_q[$];
  logic [63:0] note;
  logic [7:0]  modes[3] = '{8'h00, 8'h01, 8'h50};
  int          fail_count, n_tests;
  wire  [7:0]  bus_dq = o_dq_oe_n ? dev_dq : o_dq;
  wire         rb_n   = !rb_low;  // Pull-up; the device only pulls low
  nhc_host uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
    .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
    .i_dq(bus_dq), .i_ready_busy_n(rb_n));
  nhc_flash_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) u_dev (.i_ce_n(o_ce_n), .i_cle(o_cle),
    .i_ale(o_ale), .i_we_n(o_we_n), .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_dq(o_dq),
    .o_dq(dev_dq), .o_rb_low(rb_low));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  function automatic logic [31:0] ex(input logic [7:0] m, input logic [7:0] c);
    return {24'h0, m == 8'h50 ? {4'hE, c[3:0]} : c ^ {8{m[0]}}};
  endfunction : ex
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr
  // A zero mask marks a read whose answer the caller inspects itself
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    note_q.push_back({m, e});
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
  endtask : rd
  task automatic wt(input logic need_rdy);
    logic [31:0] v;
    for (int k = 0; k < 3000; k++) begin
      rd(nhc_pkg::OFS_STAT, 32'h0, 32'h0);
      #1 v = o_rdata;
      if (!v[nhc_pkg::STAT_ENG_BUSY_BIT] && (v[nhc_pkg::STAT_READY_BIT] || !need_rdy)) return;
    end
    fail_count++;
    $display("[FAIL] t=%0t wait expired got %h exp %h", $time, v, 32'h2);
    test_done();
  endtask : wt
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic need_rdy);
    wr(a, d);
    wt(need_rdy);
  endtask : op
  always @(posedge i_sys_clk) begin
    if (rd_p) begin
      note = note_q.pop_front();
      if (note[63:32] != 32'h0) begin
        n_tests++;
        if ((o_rdata & note[63:32]) !== note[31:0]) begin
          fail_count++;
          $display("[FAIL] t=%0t got %h exp %h", $time, o_rdata & note[63:32], note[31:0]);
        end
      end
    end
    rd_p = i_rd;
  end
  initial begin
    {i_rst_b, i_wr, i_rd, i_addr, i_wdata, rd_p} = '0;
    {fail_count, n_tests} = '0;
    lfsr_q = 32'h30EC6543;
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(nhc_pkg::OFS_CTRL, 32'h3, 32'h0);
    rd(8'h24, 32'hFFFFFFFF, 32'h0);
    wr(nhc_pkg::OFS_CTRL, 32'h3);
    op(nhc_pkg::OFS_CMD, 32'h90, 1'b1);
    op(nhc_pkg::OFS_ADDR, 32'h0, 1'b1);
    for (int j = 0; j < 2; j++) begin
      op(nhc_pkg::OFS_RDGO, 32'h0, 1'b1);
      rd(nhc_pkg::OFS_RDATA, 32'hFF, {24'h0, j == 0 ? MAKER_ID : DEV_ID});
    end
    $display("test id done");
    foreach (modes[i]) begin
      lfsr_q = rnd(lfsr_q);
      col    = lfsr_q[7:0] & 8'hFE;
      op(nhc_pkg::OFS_CMD, {24'h0, modes[i]}, 1'b1);
      op(nhc_pkg::OFS_ADDR, {10'h0, lfsr_q[21:8], col}, 1'b1);
      for (int j = 0; j < 2; j++) begin
        op(nhc_pkg::OFS_RDGO, 32'h0, 1'b1);
        rd(nhc_pkg::OFS_RDATA, 32'hFF, ex(modes[i], col + 8'(j)));
      end
    end
    $display("test read modes done");
    for (int p = 0; p < 2; p++) begin
      op(nhc_pkg::OFS_CMD, 32'h50, 1'b1);
      op(nhc_pkg::OFS_ADDR, p == 0 ? 32'h0F : 32'h3FFF0F, 1'b1);
      for (int j = 0; j < 2; j++) begin
        op(nhc_pkg::OFS_RDGO, 32'h0, 1'b0);
        rd(nhc_pkg::OFS_STAT, 32'h2, (p == 0 && j == 0) ? 32'h0 : 32'h2);
        wt(1'b1);
        rd(nhc_pkg::OFS_RDATA, 32'hFF, ex(8'h50, 8'h0F + 8'(j * (1 - p))));
      end
    end
    $display("test page wrap done");
    op(nhc_pkg::OFS_CMD, 32'h80, 1'b1);
    op(nhc_pkg::OFS_ADDR, lfsr_q & 32'h3FFF00, 1'b1);
    op(nhc_pkg::OFS_DATA, 32'hEE, 1'b1);
    op(nhc_pkg::OFS_CMD, 32'h60, 1'b1);
    rd(nhc_pkg::OFS_STAT, 32'h4, 32'h4);
    wr(nhc_pkg::OFS_STAT, 32'h4);
    rd(nhc_pkg::OFS_STAT, 32'h4, 32'h0);
    op(nhc_pkg::OFS_CMD, 32'h10, 1'b0);
    op(nhc_pkg::OFS_CMD, 32'h00, 1'b0);
    rd(nhc_pkg::OFS_STAT, 32'h4, 32'h4);
    op(nhc_pkg::OFS_CMD, 32'h70, 1'b0);
    op(nhc_pkg::OFS_RDGO, 32'h0, 1'b0);
    rd(nhc_pkg::OFS_SBYTE, 32'hFF, 32'h81);
    rd(nhc_pkg::OFS_STAT, 32'h8, 32'h0);
    wt(1'b1);
    op(nhc_pkg::OFS_RDGO, 32'h0, 1'b1);
    rd(nhc_pkg::OFS_SBYTE, 32'hFF, 32'hC1);
    rd(nhc_pkg::OFS_STAT, 32'h8, 32'h8);
    $display("test program done");
    wr(nhc_pkg::OFS_STAT, 32'h4);
    wr(nhc_pkg::OFS_CTRL, 32'h2);
    op(nhc_pkg::OFS_CMD, 32'h80, 1'b1);
    op(nhc_pkg::OFS_ADDR, 32'h0, 1'b1);
    op(nhc_pkg::OFS_DATA, 32'h0, 1'b1);
    op(nhc_pkg::OFS_CMD, 32'h10, 1'b1);
    op(nhc_pkg::OFS_CMD, 32'h70, 1'b1);
    op(nhc_pkg::OFS_RDGO, 32'h0, 1'b1);
    rd(nhc_pkg::OFS_SBYTE, 32'hFF, 32'h40);
    rd(nhc_pkg::OFS_STAT, 32'h10, 32'h10);
    $display("test protect done");
    wr(nhc_pkg::OFS_STAT, 32'h4);
    wr(nhc_pkg::OFS_CTRL, 32'h3);
    op(nhc_pkg::OFS_CMD, 32'hD0, 1'b1);
    rd(nhc_pkg::OFS_STAT, 32'h4, 32'h4);
    wr(nhc_pkg::OFS_STAT, 32'h4);
    op(nhc_pkg::OFS_CMD, 32'h60, 1'b1);
    op(nhc_pkg::OFS_ADDR, 32'h4000, 1'b1);
    op(nhc_pkg::OFS_CMD, 32'hD0, 1'b0);
    op(nhc_pkg::OFS_CMD, 32'hFF, 1'b1);
    rd(nhc_pkg::OFS_STAT, 32'h4, 32'h0);
    op(nhc_pkg::OFS_CMD, 32'h70, 1'b1);
    op(nhc_pkg::OFS_RDGO, 32'h0, 1'b1);
    rd(nhc_pkg::OFS_SBYTE, 32'hFF, 32'hC0);
    $display("test erase done");
    repeat (3) @(posedge i_sys_clk);
    test_done();
  end
endmodule : nhc_host_tb
